// File: design/dws_consts.svh
`ifndef DWS_CONSTS_SVH
`define DWS_CONSTS_SVH

// Debugger status register bit positions.
`define DWS_STAT_DEBUG_BIT 7
`define DWS_STAT_HALT_BIT 6
`define DWS_STAT_RPROT_BIT 5
`define DWS_STAT_RSVD_MSB 4

// Watch control register bit positions.
`define DWS_CTL_WRITE_BIT 7
`define DWS_CTL_READ_BIT 6
`define DWS_CTL_DMATCH_BIT 5
`define DWS_CTL_RSVD_BIT 4
`define DWS_CTL_AHIGH_MSB 3

// Reset values of the registers.
`define DWS_STATUS_RESET 8'h00
`define DWS_CTL_RESET 8'h00
`define DWS_ADDR_RESET 8'h00
`define DWS_MATCH_RESET 8'h00

// Debugger command codes and the acknowledge character.
`define DWS_CMD_WR_WATCH 8'h20
`define DWS_CMD_RD_WATCH 8'h21
`define DWS_CMD_RD_STATUS 8'h02
`define DWS_ACK_BYTE 8'hff

// Reply lengths in bytes.
`define DWS_RD_WATCH_LEN 2'h3
`define DWS_RD_STATUS_LEN 2'h1
`define DWS_ACK_LEN 2'h1

`endif

// File: design/dws_match.sv
`timescale 1ns/1ns
`include "dws_consts.svh"

module dws_match
    import dws_pkg::*;
(
    input dws_rf_access_t rf_access,
    input dws_watch_cfg_t cfg,
    output logic hit
);

    logic [11:0] watch_addr;
    logic addr_eq;
    logic data_ok;
    logic kind_ok;

    // The whole compare is combinational so a hit is seen in the access cycle itself.
    always_comb
    begin
        watch_addr = {cfg.ctl[`DWS_CTL_AHIGH_MSB:0], cfg.addr_low};
        addr_eq = (rf_access.addr == watch_addr);
        kind_ok = (rf_access.write && cfg.ctl[`DWS_CTL_WRITE_BIT])
            || (!rf_access.write && cfg.ctl[`DWS_CTL_READ_BIT]);
        // Without a read or write enable kind_ok is low, so data match alone does nothing.
        data_ok = !cfg.ctl[`DWS_CTL_DMATCH_BIT]
            || (rf_access.data == cfg.match);
        hit = rf_access.valid && addr_eq && kind_ok && data_ok;
    end

endmodule

// File: design/dws_pkg.sv
package dws_pkg;

    // One register-file access cycle as seen by the watchpoint.
    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
        logic [7:0] data;
    } dws_rf_access_t;

    // The three watchpoint registers travelling together.
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] addr_low;
        logic [7:0] match;
    } dws_watch_cfg_t;

    // Command parser states.
    typedef enum logic [1:0] {
        DWS_IDLE,
        DWS_WR_CTL,
        DWS_WR_ADDR,
        DWS_WR_DATA
    } dws_state_t;

endpackage

// File: design/dws_reply.sv
`timescale 1ns/1ns
`include "dws_consts.svh"

module dws_reply
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic load_valid,
    input wire logic [23:0] load_bytes,
    input wire logic [1:0] load_count,
    input wire logic ack_req,
    output logic busy,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    input wire logic rsp_ready
);

    logic [23:0] shift_q;
    logic [23:0] shift_d;
    logic [1:0] count_q;
    logic [1:0] count_d;
    logic ack_pending_q;
    logic ack_pending_d;
    logic ack_take;

    // A command reply wins the idle slot; a pending acknowledge waits for the next one.
    always_comb
    begin
        shift_d = shift_q;
        count_d = count_q;
        ack_take = 1'b0;
        if (count_q != 2'h0)
        begin
            if (rsp_ready)
            begin
                shift_d = {shift_q[15:0], 8'h00};
                count_d = count_q - 2'h1;
            end
        end
        else if (load_valid)
        begin
            shift_d = load_bytes;
            count_d = load_count;
        end
        else if (ack_pending_q)
        begin
            shift_d = {`DWS_ACK_BYTE, 16'h0000};
            count_d = `DWS_ACK_LEN;
            ack_take = 1'b1;
        end
        // A new acknowledge request in the cycle the old one is taken is kept.
        ack_pending_d = ack_req || (ack_pending_q && !ack_take);
    end

    // Reply storage registers.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            shift_q <= 24'h000000;
            count_q <= 2'h0;
            ack_pending_q <= 1'b0;
        end
        else
        begin
            shift_q <= shift_d;
            count_q <= count_d;
            ack_pending_q <= ack_pending_d;
        end
    end

    assign busy = (count_q != 2'h0);
    assign rsp_valid = busy;
    assign rsp_data = shift_q[23:16];

endmodule

// File: design/dws_top.sv
`timescale 1ns/1ns
`include "dws_consts.svh"

module dws_top
    import dws_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    input wire logic rsp_ready,
    input dws_rf_access_t rf_access,
    input wire logic halt_active,
    input wire logic read_protect_option_n,
    input wire logic debug_enter_req,
    input wire logic debug_exit_req,
    input wire logic break_ack_enable,
    input wire logic break_instr_req,
    output logic debug_mode_bit,
    output logic watch_break,
    output logic [7:0] debugger_status
);

    dws_state_t state_q;
    dws_state_t state_d;
    dws_watch_cfg_t cfg_q;
    dws_watch_cfg_t cfg_d;
    logic wr_allowed_q;
    logic wr_allowed_d;
    logic debug_mode_q;
    logic debug_mode_d;
    logic break_q;
    logic break_d;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic read_protect_flag;
    logic debug_active_flag;
    logic watch_hit;
    logic take;
    logic reply_busy;
    logic load_valid;
    logic [23:0] load_bytes;
    logic [1:0] load_count;
    logic ack_req;

    // The option bit is active low: a programmed zero turns protection on.
    assign read_protect_flag = !read_protect_option_n;
    assign debug_active_flag = debug_mode_q;

    // Commands stall while a reply drains so a readback never overwrites one in flight.
    assign cmd_ready = !reply_busy;
    assign take = cmd_valid && cmd_ready;

    // Watchpoint comparator on the live register-file access.
    dws_match u_match
    (
        .rf_access(rf_access),
        .cfg(cfg_q),
        .hit(watch_hit)
    );

    // Byte serialiser toward the debug host.
    dws_reply u_reply
    (
        .ref_clk(ref_clk),
        .reset(reset),
        .load_valid(load_valid),
        .load_bytes(load_bytes),
        .load_count(load_count),
        .ack_req(ack_req),
        .busy(reply_busy),
        .rsp_valid(rsp_valid),
        .rsp_data(rsp_data),
        .rsp_ready(rsp_ready)
    );

    // Command parser: writes the watch registers and starts readback replies.
    always_comb
    begin
        state_d = state_q;
        cfg_d = cfg_q;
        wr_allowed_d = wr_allowed_q;
        load_valid = 1'b0;
        load_bytes = 24'h000000;
        load_count = 2'h0;
        case (state_q)
            DWS_IDLE:
            begin
                if (take)
                begin
                    if (cmd_byte == `DWS_CMD_WR_WATCH)
                    begin
                        wr_allowed_d = debug_active_flag && !read_protect_flag;
                        if (!debug_active_flag || read_protect_flag)
                        begin
                            cfg_d.ctl = `DWS_CTL_RESET;
                        end
                        state_d = DWS_WR_CTL;
                    end
                    else if (cmd_byte == `DWS_CMD_RD_WATCH)
                    begin
                        load_valid = 1'b1;
                        load_bytes = {cfg_q.ctl, cfg_q.addr_low, cfg_q.match};
                        load_count = `DWS_RD_WATCH_LEN;
                    end
                    else if (cmd_byte == `DWS_CMD_RD_STATUS)
                    begin
                        load_valid = 1'b1;
                        load_bytes = {status_q, 16'h0000};
                        load_count = `DWS_RD_STATUS_LEN;
                    end
                end
            end
            DWS_WR_CTL:
            begin
                if (take)
                begin
                    if (wr_allowed_q && !read_protect_flag)
                    begin
                        // Reserved bit 4 is stored as written; the host keeps it zero.
                        cfg_d.ctl = cmd_byte;
                    end
                    else
                    begin
                        cfg_d.ctl = `DWS_CTL_RESET;
                    end
                    state_d = DWS_WR_ADDR;
                end
            end
            DWS_WR_ADDR:
            begin
                if (take)
                begin
                    if (wr_allowed_q)
                    begin
                        cfg_d.addr_low = cmd_byte;
                    end
                    state_d = DWS_WR_DATA;
                end
            end
            DWS_WR_DATA:
            begin
                if (take)
                begin
                    if (wr_allowed_q)
                    begin
                        cfg_d.match = cmd_byte;
                    end
                    state_d = DWS_IDLE;
                end
            end
            default:
            begin
                state_d = DWS_IDLE;
            end
        endcase
        // Protection turning on later still drops any enable that slipped in.
        if (read_protect_flag)
        begin
            cfg_d.ctl[`DWS_CTL_WRITE_BIT] = 1'b0;
            cfg_d.ctl[`DWS_CTL_READ_BIT] = 1'b0;
            cfg_d.ctl[`DWS_CTL_DMATCH_BIT] = 1'b0;
        end
    end

    // Debug-mode bit, break pulse, acknowledge request and status snapshot.
    always_comb
    begin
        break_d = watch_hit;
        // A hit or entry request beats an exit request in the same cycle.
        debug_mode_d = debug_mode_q;
        if (debug_exit_req && !read_protect_flag)
        begin
            debug_mode_d = 1'b0;
        end
        if (watch_hit || debug_enter_req || break_instr_req)
        begin
            debug_mode_d = 1'b1;
        end
        ack_req = break_ack_enable && (watch_hit || break_instr_req);
        status_d = `DWS_STATUS_RESET;
        status_d[`DWS_STAT_DEBUG_BIT] = debug_mode_q;
        status_d[`DWS_STAT_HALT_BIT] = halt_active;
        status_d[`DWS_STAT_RPROT_BIT] = read_protect_flag;
    end

    // State registers of the whole block.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_q <= DWS_IDLE;
            cfg_q <= {`DWS_CTL_RESET, `DWS_ADDR_RESET, `DWS_MATCH_RESET};
            wr_allowed_q <= 1'b0;
            debug_mode_q <= 1'b0;
            break_q <= 1'b0;
            status_q <= `DWS_STATUS_RESET;
        end
        else
        begin
            state_q <= state_d;
            cfg_q <= cfg_d;
            wr_allowed_q <= wr_allowed_d;
            debug_mode_q <= debug_mode_d;
            break_q <= break_d;
            status_q <= status_d;
        end
    end

    assign debug_mode_bit = debug_mode_q;
    assign watch_break = break_q;
    assign debugger_status = status_q;

    default clocking dws_cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    a_status_low_zero: assert property (debugger_status[`DWS_STAT_RSVD_MSB:0] == 5'h00)
        else $error("status low bits not zero");

    a_status_debug_bit: assert property ($past(debug_mode_q)
        |-> debugger_status[7] == 1'b1)
        else $error("status debug bit does not follow debug mode");

    a_status_run_bit: assert property (!$past(debug_mode_q)
        |-> debugger_status[7] == 1'b0)
        else $error("status debug bit set while running");

    a_status_halt_bit: assert property (debugger_status[6] == $past(halt_active))
        else $error("status halt bit wrong");

    a_status_protect_bit: assert property (debugger_status[5]
        == !$past(read_protect_option_n))
        else $error("status protect bit wrong");

    a_write_needs_enable: assert property (rf_access.valid && rf_access.write
        && !cfg_q.ctl[7] |-> !watch_hit)
        else $error("write break without write enable");

    a_read_needs_enable: assert property (rf_access.valid && !rf_access.write
        && !cfg_q.ctl[6] |-> !watch_hit)
        else $error("read break without read enable");

    a_write_hit_seen: assert property (rf_access.valid && rf_access.write
        && cfg_q.ctl[7] && !cfg_q.ctl[5]
        && rf_access.addr == {cfg_q.ctl[3:0], cfg_q.addr_low}
        |=> watch_break && debug_mode_q)
        else $error("enabled write access did not break");

    a_protect_blocks_set: assert property (read_protect_flag |=> cfg_q.ctl[7:5] == 3'h0)
        else $error("enable bit set under read protection");

    a_data_match_only: assert property (watch_hit && cfg_q.ctl[5]
        |-> rf_access.data == cfg_q.match)
        else $error("data match break on unequal data");

    a_address_full: assert property (watch_hit
        |-> rf_access.addr == {cfg_q.ctl[3:0], cfg_q.addr_low})
        else $error("break on wrong address");

    a_hit_enters_debug: assert property (watch_hit
        |=> debug_mode_q ##1 debugger_status[7])
        else $error("hit did not enter debug mode");

    a_denied_clears: assert property (state_q == DWS_IDLE && take
        && cmd_byte == `DWS_CMD_WR_WATCH && !debug_mode_q
        |=> cfg_q.ctl == 8'h00 ##1 cfg_q.ctl == 8'h00)
        else $error("denied watch write left control bits");

    a_readback_order: assert property (state_q == DWS_IDLE && take
        && cmd_byte == `DWS_CMD_RD_WATCH
        |=> rsp_valid && rsp_data == $past(cfg_q.ctl))
        else $error("readback does not start with control byte");

    a_read_hit_seen: assert property (rf_access.valid && !rf_access.write
        && cfg_q.ctl[6] && !cfg_q.ctl[5]
        && rf_access.addr == {cfg_q.ctl[3:0], cfg_q.addr_low}
        |=> watch_break && debug_mode_q)
        else $error("enabled read access did not break");

    a_match_value_hit: assert property (rf_access.valid && rf_access.write
        && cfg_q.ctl[7] && cfg_q.ctl[5] && rf_access.data == cfg_q.match
        && rf_access.addr == {cfg_q.ctl[3:0], cfg_q.addr_low}
        |=> watch_break)
        else $error("write with matching data did not break");

    a_data_needs_kind: assert property (rf_access.valid
        && cfg_q.ctl[7:6] == 2'h0 |-> !watch_hit)
        else $error("data match alone caused a break");

endmodule

// File: verification/debug_watchpoint_status_test.sv
`timescale 1ns/1ns
`include "dws_consts.svh"

module debug_watchpoint_status_test
    import dws_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid, cmd_ready, rsp_valid, rsp_ready, watch_break, debug_mode_bit;
    logic [7:0] cmd_byte, rsp_data, debugger_status;
    dws_rf_access_t rf_acc = '0;
    logic halt_active = 1'b0;
    logic opt_n = 1'b1;
    logic enter_req = 1'b0;
    logic exit_req = 1'b0;
    logic ack_en = 1'b0;
    logic brk_req = 1'b0;
    integer seed = 32'h16d1;
    int err_total = 0;
    int total_checks = 0;

    // Free-running system clock, 4 ns period.
    always #2 ref_clk = ~ref_clk;

    dws_top i_dws_top (.ref_clk(ref_clk), .reset(reset), .cmd_valid(cmd_valid),
        .cmd_byte(cmd_byte), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_ready(rsp_ready), .rf_access(rf_acc),
        .halt_active(halt_active), .read_protect_option_n(opt_n),
        .debug_enter_req(enter_req), .debug_exit_req(exit_req), .break_ack_enable(ack_en),
        .break_instr_req(brk_req), .debug_mode_bit(debug_mode_bit),
        .watch_break(watch_break), .debugger_status(debugger_status));

    dws_host i_dws_host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_ready(rsp_ready));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // A hit needs the full address, the enable of the access kind and, if asked, the data.
    function automatic logic exp_hit(dws_rf_access_t a, logic [7:0] c, logic [7:0] lo,
        logic [7:0] m);
        return a.valid && a.addr == {c[3:0], lo} && (a.write ? c[7] : c[6])
            && (!c[5] || a.data == m);
    endfunction

    // One-cycle pulse on the enter or exit request, then one idle edge.
    task automatic mode_pulse(input logic enter);
        if (enter)
            enter_req <= 1'b1;
        else
            exit_req <= 1'b1;
        @(posedge ref_clk);
        enter_req <= 1'b0;
        exit_req <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic read_back(input logic [7:0] c, input logic [7:0] a, input logic [7:0] m);
        i_dws_host.request(`DWS_CMD_RD_WATCH, 3);
        check("ctl", i_dws_host.rx_q[0], c);
        check("addr", i_dws_host.rx_q[1], a);
        check("match", i_dws_host.rx_q[2], m);
        check("ready", cmd_ready, 8'h01);
    endtask

    // Cuts a hang short well beyond the expected run length.
    initial
    begin
        #200000;
        err_total++;
        give_verdict();
    end

    // Main sequence: every enable combination with random accesses, then corner cases.
    initial
    begin
        dws_rf_access_t a, prev;
        logic [7:0] c, lo, m;
        logic old_dbg, hit, h, prev_halt;
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        @(negedge ref_clk);
        check("status", debugger_status, 8'h00);
        @(posedge ref_clk);
        read_back(8'h00, 8'h00, 8'h00);
        for (int r = 0; r < 8; r++)
        begin
            c = {r[2:0], 1'b0, 4'($random(seed))};
            lo = 8'($random(seed));
            m = 8'($random(seed));
            mode_pulse(1'b1);
            i_dws_host.slow = r[0];
            i_dws_host.write_watch(c, lo, m);
            read_back(c, lo, m);
            mode_pulse(1'b0);
            old_dbg = 1'b0;
            prev = '0;
            prev_halt = halt_active;
            for (int i = 0; i <= 24; i++)
            begin
                a.valid = ($random(seed) % 8) != 0;
                a.write = 1'($random(seed));
                a.addr = ($random(seed) & 1) ? {c[3:0], lo} : 12'($random(seed));
                a.data = ($random(seed) & 1) ? m : 8'($random(seed));
                if (i == 24)
                    a = '0;
                h = 1'($random(seed));
                rf_acc <= a;
                halt_active <= h;
                @(negedge ref_clk);
                hit = exp_hit(prev, c, lo, m);
                check("break", watch_break, hit);
                check("debug_mode_bit", debug_mode_bit, old_dbg | hit);
                check("status", debugger_status, {old_dbg, prev_halt, 6'h00});
                old_dbg = old_dbg | hit;
                prev = a;
                prev_halt = h;
                @(posedge ref_clk);
            end
        end
        ack_en <= 1'b1;
        mode_pulse(1'b1);
        i_dws_host.write_watch(8'h81, 8'h5a, 8'h00);
        mode_pulse(1'b0);
        i_dws_host.rx_q.delete();
        rf_acc <= '{1'b1, 1'b1, 12'h15a, 8'h3c};
        @(posedge ref_clk);
        rf_acc <= '0;
        i_dws_host.finish_cmd(1);
        check("ack", i_dws_host.rx_q[0], `DWS_ACK_BYTE);
        check("debug_mode_bit", debug_mode_bit, 8'h01);
        mode_pulse(1'b0);
        i_dws_host.rx_q.delete();
        brk_req <= 1'b1;
        @(posedge ref_clk);
        brk_req <= 1'b0;
        i_dws_host.finish_cmd(1);
        check("brkack", i_dws_host.rx_q[0], `DWS_ACK_BYTE);
        check("brkstat", debugger_status[7], 8'h01);
        ack_en <= 1'b0;
        mode_pulse(1'b0);
        i_dws_host.write_watch(8'he5, 8'h11, 8'h22);
        read_back(8'h00, 8'h5a, 8'h00);
        mode_pulse(1'b1);
        opt_n <= 1'b0;
        halt_active <= 1'b1;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        check("status", debugger_status, 8'he0);
        @(posedge ref_clk);
        i_dws_host.request(`DWS_CMD_RD_STATUS, 1);
        check("statread", i_dws_host.rx_q[0], 8'he0);
        i_dws_host.write_watch(8'he1, 8'h33, 8'h44);
        read_back(8'h00, 8'h5a, 8'h00);
        give_verdict();
    end
endmodule

// File: verification/dws_host.sv
`timescale 1ns/1ns
`include "dws_consts.svh"

// Behavioural debug host that sends command bytes and collects reply bytes.
module dws_host
(
    input wire logic ref_clk,
    output logic cmd_valid,
    output logic [7:0] cmd_byte,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    output logic rsp_ready
);
    logic [7:0] rx_q[$];
    logic slow = 1'b0;

    // Quiet command bus at time zero.
    initial
    begin
        cmd_valid = 1'b0;
        cmd_byte = 8'h00;
        rsp_ready = 1'b0;
    end

    // A slow host takes reply bytes only every other cycle, which stalls the reply path.
    always @(posedge ref_clk)
    begin
        if (rsp_valid && rsp_ready)
            rx_q.push_back(rsp_data);
        rsp_ready <= slow ? !rsp_ready : 1'b1;
    end

    // Holds the byte until an edge samples cmd_ready high.
    task automatic send(input logic [7:0] b);
        cmd_valid <= 1'b1;
        cmd_byte <= b;
        @(posedge ref_clk);
        for (int n = 0; n < 64 && !cmd_ready; n++)
            @(posedge ref_clk);
        // A byte that is never taken is a failure of the run, not a silent skip.
        if (!cmd_ready)
            debug_watchpoint_status_test.err_total++;
    endtask

    // The released bus shows the inverse of its last byte, so stale data cannot match.
    task automatic finish_cmd(input int n);
        cmd_valid <= 1'b0;
        cmd_byte <= ~cmd_byte;
        for (int k = 0; k < 64 && rx_q.size() < n; k++)
            @(posedge ref_clk);
        @(posedge ref_clk);
        if (rx_q.size() < n)
            debug_watchpoint_status_test.err_total++;
    endtask

    task automatic write_watch(input logic [7:0] c, input logic [7:0] a, input logic [7:0] m);
        send(`DWS_CMD_WR_WATCH);
        send(c & 8'hef);
        send(a);
        send(m);
        finish_cmd(0);
    endtask

    task automatic request(input logic [7:0] code, input int n);
        rx_q.delete();
        send(code);
        finish_cmd(n);
    endtask
endmodule
